/* File: rtl/supply_regs_map.svh */
// Register offsets, field positions, reset values and threshold figures
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef SUPPLY_REGS_MAP_SVH
`define SUPPLY_REGS_MAP_SVH

`define REG_REGULATOR_OFS 6'h10
`define REG_MONITOR_OFS 6'h11

`define REGULATOR_ANALOG_EXT_BIT 7
`define REGULATOR_ANALOG_OK_BIT 6
`define REGULATOR_DIGITAL_EXT_BIT 3
`define REGULATOR_DIGITAL_OK_BIT 2

`define MONITOR_ABOVE_BIT 5
`define MONITOR_RANGE_BIT 4
`define MONITOR_CODE_MSB 3

`define MONITOR_CODE_RESET 4'h2
`define MONITOR_RANGE_RESET 1'h0

// Thresholds in millivolts
`define THR_LOW_BASE_MV 11'h6A4
`define THR_LOW_STEP_MV 11'h032
`define THR_HIGH_BASE_MV 12'h9F6
`define THR_HIGH_STEP_MV 12'h04B

`endif

/* File: rtl/supply_regs_pkg.sv */
// Types shared by the supply regulator and monitor register bank
package supply_regs_pkg;
    typedef enum logic [1:0] {
        PWR_ON,
        PWR_SLEEP,
        PWR_ACTIVE
    } power_state_e;
endpackage : supply_regs_pkg

/* File: rtl/supply_threshold_table.sv */
// Threshold code to millivolt table for the supply monitor
`include "supply_regs_map.svh"

module supply_threshold_table (
    input wire logic i_clk, // Register clock
    input wire logic i_srst, // Synchronous reset, active high
    input wire logic [3:0] i_threshold_code, // Programmed threshold code
    input wire logic i_threshold_high_range, // Range select
    output logic [11:0] o_threshold_mv // Threshold in millivolts, registered
);
    typedef struct packed {
        logic [11:0] mv;
    } table_state_s;

    table_state_s state;
    table_state_s next_state;
    logic [11:0] low_mv;
    logic [11:0] high_mv;

    always_comb begin
        next_state = state;
        low_mv = {1'b0, `THR_LOW_BASE_MV}
            + 12'(i_threshold_code) * {1'b0, `THR_LOW_STEP_MV};
        high_mv = `THR_HIGH_BASE_MV
            + 12'(i_threshold_code) * `THR_HIGH_STEP_MV;
        next_state.mv = i_threshold_high_range ? high_mv : low_mv;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_threshold_mv = state.mv;

    chk_table_code_zero : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_threshold_code == 4'h0 && !i_threshold_high_range)
        |=> (o_threshold_mv == 12'h6A4))
        else $error("low range code zero is not 1.70V");
    chk_table_high_top : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_threshold_code == 4'hF && i_threshold_high_range)
        |=> (o_threshold_mv == 12'hE5B))
        else $error("high range code fifteen is not 3.675V");
endmodule : supply_threshold_table

/* File: rtl/supply_regs.sv */
// Regulator control and supply monitor register bank
`include "supply_regs_map.svh"

module supply_regs (
    input wire logic i_clk, // Internal digital clock, 25 MHz
    input wire logic i_srst, // Synchronous reset, active high
    input wire logic [5:0] i_reg_addr, // Register address from SPI
    input wire logic i_reg_wr, // Write strobe, one cycle
    input wire logic i_reg_rd, // Read strobe, one cycle
    input wire logic [7:0] i_reg_wdata, // Write data
    output logic [7:0] o_reg_rdata, // Read data, registered
    input wire logic i_analog_settled_raw, // Analog supply settled, async
    input wire logic i_digital_settled_raw, // Digital supply settled, async
    input wire logic i_comparator_raw, // Supply above threshold, async
    input wire supply_regs_pkg::power_state_e i_power_state, // Device state
    output logic o_analog_regulator_off, // Analog regulator disable
    output logic o_digital_regulator_off, // Digital regulator disable
    output logic o_monitor_enable, // Comparator enable
    output logic [3:0] o_threshold_code, // Threshold code to comparator
    output logic o_threshold_high_range, // Range select to comparator
    output logic [11:0] o_threshold_mv, // Threshold in millivolts
    output logic o_low_supply_irq // Low supply event, one cycle
);
    typedef struct packed {
        logic analog_ext;
        logic digital_ext;
        logic [3:0] code;
        logic high_range;
        logic [1:0] ana_sync;
        logic [1:0] dig_sync;
        logic [1:0] cmp_sync;
        logic above;
        logic irq;
        logic [7:0] rdata;
    } regs_state_s;

    regs_state_s state;
    regs_state_s next_state;
    logic monitor_on;
    logic analog_ok;
    logic digital_ok;
    logic [7:0] regulator_view;
    logic [7:0] monitor_view;

    // ----------------------------------------------------------------
    // Status views
    // ----------------------------------------------------------------
    assign monitor_on = (i_power_state == supply_regs_pkg::PWR_ACTIVE);
    // Digital status is forced on a read: reads need the digital supply up
    assign analog_ok = state.analog_ext | state.ana_sync[1];
    assign digital_ok = state.digital_ext | state.dig_sync[1]
        | i_reg_rd;

    always_comb begin
        regulator_view = 8'h00;
        regulator_view[`REGULATOR_ANALOG_EXT_BIT] = state.analog_ext;
        regulator_view[`REGULATOR_ANALOG_OK_BIT] = analog_ok;
        regulator_view[`REGULATOR_DIGITAL_EXT_BIT] = state.digital_ext;
        regulator_view[`REGULATOR_DIGITAL_OK_BIT] = digital_ok;
        monitor_view = 8'h00;
        monitor_view[`MONITOR_ABOVE_BIT] = state.above;
        monitor_view[`MONITOR_RANGE_BIT] = state.high_range;
        monitor_view[`MONITOR_CODE_MSB:0] = state.code;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.irq = 1'b0;
        // Bit [0] is the first stage; only bit [1] may feed logic
        next_state.ana_sync = {state.ana_sync[0], i_analog_settled_raw};
        next_state.dig_sync = {state.dig_sync[0], i_digital_settled_raw};
        next_state.cmp_sync = {state.cmp_sync[0], i_comparator_raw};
        if (i_reg_wr && i_reg_addr == `REG_REGULATOR_OFS) begin
            next_state.analog_ext =
                i_reg_wdata[`REGULATOR_ANALOG_EXT_BIT];
            next_state.digital_ext =
                i_reg_wdata[`REGULATOR_DIGITAL_EXT_BIT];
        end
        if (i_reg_wr && i_reg_addr == `REG_MONITOR_OFS) begin
            next_state.code = i_reg_wdata[`MONITOR_CODE_MSB:0];
            next_state.high_range = i_reg_wdata[`MONITOR_RANGE_BIT];
        end
        // Above only follows the synchronised comparator while active;
        // in power-on or sleep it is held at zero, so a later wake with
        // a low supply cannot produce a one-to-zero edge
        if (monitor_on) begin
            next_state.above = state.cmp_sync[1];
        end else begin
            next_state.above = 1'b0;
        end
        // Fall of the registered bit; a bit that was never one cannot fall
        next_state.irq = monitor_on && state.above
            && !state.cmp_sync[1];
        if (i_reg_rd) begin
            case (i_reg_addr)
                `REG_REGULATOR_OFS: next_state.rdata = regulator_view;
                `REG_MONITOR_OFS: next_state.rdata = monitor_view;
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= '0;
            state.code <= `MONITOR_CODE_RESET;
            state.high_range <= `MONITOR_RANGE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Threshold lookup
    // ----------------------------------------------------------------
    supply_threshold_table u_table (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_threshold_code(state.code),
        .i_threshold_high_range(state.high_range),
        .o_threshold_mv(o_threshold_mv)
    );

    assign o_reg_rdata = state.rdata;
    assign o_analog_regulator_off = state.analog_ext;
    assign o_digital_regulator_off = state.digital_ext;
    assign o_monitor_enable = monitor_on;
    assign o_threshold_code = state.code;
    assign o_threshold_high_range = state.high_range;
    assign o_low_supply_irq = state.irq;

    // ----------------------------------------------------------------
    // Checks: regulator register
    // ----------------------------------------------------------------
    chk_analog_off_write : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == 6'h10)
        |=> (o_analog_regulator_off == $past(i_reg_wdata[7])))
        else $error("analog regulator select not taken from bit 7");

    chk_digital_off_write : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == 6'h10)
        |=> (o_digital_regulator_off == $past(i_reg_wdata[3])))
        else $error("digital regulator select not taken from bit 3");

    chk_regulator_hold : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !(i_reg_wr && i_reg_addr == 6'h10)
        |=> ($stable(o_analog_regulator_off)
            && $stable(o_digital_regulator_off)))
        else $error("regulator selects changed without a write");

    chk_reset_offs : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $fell(i_srst)
        |-> (!o_analog_regulator_off && !o_digital_regulator_off))
        else $error("regulator selects not zero after reset");

    chk_ext_read_back : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 6'h10)
        |=> (o_reg_rdata[7] == $past(o_analog_regulator_off)
            && o_reg_rdata[3] == $past(o_digital_regulator_off)))
        else $error("regulator selects not read back");

    chk_analog_ok_ext : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 6'h10 && o_analog_regulator_off)
        |=> o_reg_rdata[6])
        else $error("analog settled not one with external select");

    chk_analog_ok_sync : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 6'h10 && !o_analog_regulator_off)
        |=> (o_reg_rdata[6] == $past(state.ana_sync[1])))
        else $error("analog settled does not follow its synchroniser");

    chk_digital_ok_read : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 6'h10)
        |=> o_reg_rdata[2])
        else $error("digital settled not one on a register read");

    // Settled inputs are asynchronous, so both stages must be present
    chk_sync_stages : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !$past(i_srst)
        |-> (state.ana_sync[1] == $past(state.ana_sync[0])
            && state.dig_sync[1] == $past(state.dig_sync[0])))
        else $error("settled synchroniser skipped a stage");

    chk_reserved_zero : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 6'h10)
        |=> (o_reg_rdata[5:4] == 2'h0 && o_reg_rdata[1:0] == 2'h0))
        else $error("reserved regulator bits not zero");

    // ----------------------------------------------------------------
    // Checks: monitor register and read path
    // ----------------------------------------------------------------
    chk_code_write : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == 6'h11)
        |=> (o_threshold_code == $past(i_reg_wdata[3:0])
            && o_threshold_high_range == $past(i_reg_wdata[4])))
        else $error("threshold fields not written");

    chk_code_hold : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !(i_reg_wr && i_reg_addr == 6'h11)
        |=> ($stable(o_threshold_code) && $stable(o_threshold_high_range)))
        else $error("threshold fields changed without a write");

    chk_reset_code : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $fell(i_srst)
        |-> (o_threshold_code == 4'h2 && !o_threshold_high_range))
        else $error("threshold fields not at their reset values");

    chk_monitor_read : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 6'h11)
        |=> (o_reg_rdata[5:0] == $past({state.above,
            o_threshold_high_range, o_threshold_code})))
        else $error("monitor register fields not read back");

    chk_monitor_reserved : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == 6'h11)
        |=> (o_reg_rdata[7:6] == 2'h0))
        else $error("reserved monitor bits not zero");

    chk_unmapped_read : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr != 6'h10 && i_reg_addr != 6'h11)
        |=> (o_reg_rdata == 8'h00))
        else $error("unmapped read did not return zero");

    chk_rdata_hold : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !i_reg_rd
        |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");

    // The threshold is registered, so its first value follows reset
    chk_mv_range : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !$past(i_srst)
        |-> (o_threshold_mv >= 12'h6A4 && o_threshold_mv <= 12'hE5B))
        else $error("threshold outside the table range");

    // ----------------------------------------------------------------
    // Checks: comparison bit and interrupt
    // ----------------------------------------------------------------
    chk_irq_on_fall : assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_low_supply_irq
        |-> ($past(state.above) && !state.above))
        else $error("interrupt without a one-to-zero fall");

    chk_fall_raises_irq : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (monitor_on && state.above && !state.cmp_sync[1])
        |=> o_low_supply_irq)
        else $error("one-to-zero fall raised no interrupt");

    chk_irq_one_cycle : assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_low_supply_irq
        |=> !o_low_supply_irq)
        else $error("interrupt pulse longer than one cycle");

    chk_irq_sleep : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !monitor_on
        |=> (!o_low_supply_irq && !state.above))
        else $error("monitor acted outside the active state");

    chk_irq_active_only : assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_low_supply_irq
        |-> $past(monitor_on))
        else $error("interrupt decided while the monitor was off");

    chk_wake_no_irq : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (monitor_on && !$past(monitor_on))
        |=> !o_low_supply_irq)
        else $error("interrupt right after the monitor woke");

    chk_low_stays_quiet : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !state.above
        |=> !o_low_supply_irq)
        else $error("interrupt while the comparison bit was zero");

    chk_cmp_latency : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (monitor_on && $past(monitor_on) && $past(monitor_on, 2)
            && $past(monitor_on, 3))
        |-> (state.above == $past(i_comparator_raw, 3)))
        else $error("comparison bit not three cycles behind comparator");

    chk_above_follows : assert property (
        @(posedge i_clk) disable iff (i_srst)
        (monitor_on && state.cmp_sync[1])
        |=> state.above)
        else $error("comparison bit missed a high comparator");
endmodule : supply_regs

/* File: tb/supply_env_model.sv */
// Regulator and comparator surroundings of the register bank
module supply_env_model (
    input wire logic [11:0] i_threshold_mv, // Threshold from the bank
    input wire logic i_analog_off, // Analog regulator disabled
    input wire logic i_digital_off, // Digital regulator disabled
    input wire logic i_analog_ready, // Analog bypass caps charged
    input wire logic i_digital_ready, // Digital bypass caps charged
    input var int i_supply_mv, // External supply in millivolts
    output logic o_analog_settled_raw, // Analog settled, internal only
    output logic o_digital_settled_raw, // Digital settled, internal only
    output logic o_comparator_raw // Supply above threshold
);
    timeunit 1ns;
    timeprecision 100ps;
    // A regulator that is off never reports settled by itself
    assign o_analog_settled_raw = !i_analog_off && i_analog_ready;
    assign o_digital_settled_raw = !i_digital_off && i_digital_ready;
    // Comparator runs free; gating by power state is the bank's job
    assign o_comparator_raw = i_supply_mv > int'(i_threshold_mv);
endmodule : supply_env_model

/* File: tb/test_supply_regs.sv */
// Self-checking bench for the supply regulator and monitor registers
module test_supply_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk, i_srst, i_reg_wr, i_reg_rd, a_raw, d_raw, c_raw;
    logic [5:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, rv;
    logic a_rdy, d_rdy, a_off, d_off, mon_en, hr_o, irq, ea, ed, m_hr, m_ab;
    logic [3:0] code_o, m_code;
    logic [11:0] thr_mv;
    logic [31:0] rng;
    supply_regs_pkg::power_state_e i_power_state;
    int supply_mv, err_total, check_count, irq_seen, irq_exp, thr;
    supply_regs dut_u (.i_clk(i_clk), .i_srst(i_srst),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_analog_settled_raw(a_raw), .i_digital_settled_raw(d_raw),
        .i_comparator_raw(c_raw), .i_power_state(i_power_state),
        .o_analog_regulator_off(a_off), .o_digital_regulator_off(d_off),
        .o_monitor_enable(mon_en), .o_threshold_code(code_o),
        .o_threshold_high_range(hr_o), .o_threshold_mv(thr_mv),
        .o_low_supply_irq(irq));
    supply_env_model env_u (.i_threshold_mv(thr_mv), .i_analog_off(a_off),
        .i_digital_off(d_off), .i_analog_ready(a_rdy),
        .i_digital_ready(d_rdy), .i_supply_mv(supply_mv),
        .o_analog_settled_raw(a_raw), .o_digital_settled_raw(d_raw),
        .o_comparator_raw(c_raw));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // An idle edge first, so back-to-back calls never drive a strobe twice
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #2 i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(posedge i_clk);
        #2 i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge i_clk);
        #2 i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(posedge i_clk);
        #2 i_reg_rd = 1'b0;
        rv = o_reg_rdata;
    endtask : rd
    // Sync and pulse latency is three edges; six leaves margin
    task automatic step(input logic act);
        logic nxt;
        nxt = act && (supply_mv > thr);
        if (m_ab && !nxt && act) irq_exp++;
        m_ab = nxt;
        repeat (6) @(posedge i_clk);
        #2;
    endtask : step
    task automatic set_thr(input logic [7:0] d);
        m_code = d[3:0];
        m_hr = d[4];
        thr = m_hr ? 2550 + 75 * m_code : 1700 + 50 * m_code;
        wr(6'h11, d);
        step(1'b1);
        rd(6'h11);
        check({4'h0, rv}, {6'h00, m_ab, m_hr, m_code});
        check(thr_mv, 12'(thr));
        check({hr_o, code_o}, {7'h00, m_hr, m_code});
        check(12'(irq_seen), 12'(irq_exp));
    endtask : set_thr
    always @(posedge i_clk) if (irq === 1'b1) irq_seen++;
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        #400000;
        err_total++;
        tally_and_finish;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {i_srst, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = 17'h10000;
        {a_rdy, d_rdy, m_ab, m_hr, m_code} = 8'h42;
        i_power_state = supply_regs_pkg::PWR_ON;
        supply_mv = 1750;
        thr = 1800;
        rng = 32'h0000762F;
        repeat (3) @(posedge i_clk);
        #2 i_srst = 1'b0;
        step(1'b0);
        check(thr_mv, 12'h708);
        rd(6'h10);
        check({4'h0, rv}, 12'h004);
        rd(6'h11);
        check({4'h0, rv}, 12'h002);
        wr(6'h12, 8'hFF);
        rd(6'h3F);
        check({4'h0, rv}, 12'h000);
        $display("test reset done");
        wr(6'h10, 8'h88);
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            {ea, ed, a_rdy, d_rdy} = {rng[7], rng[3], rng[9], rng[10]};
            wr(6'h10, rng[7:0]);
            step(1'b0);
            rd(6'h10);
            check({4'h0, rv}, {4'h0, ea, ea | a_rdy, 2'b00, ed, 3'h4});
            check({10'h000, a_off, d_off}, {10'h000, ea, ed});
        end
        $display("test regulator done");
        i_power_state = supply_regs_pkg::PWR_ACTIVE;
        step(1'b1);
        check(12'(irq_seen), 12'(irq_exp));
        check({11'h000, mon_en}, 12'h001);
        supply_mv = 3000;
        step(1'b1);
        supply_mv = 1750;
        step(1'b1);
        set_thr(8'hEF);
        supply_mv = 3000;
        step(1'b1);
        i_power_state = supply_regs_pkg::PWR_SLEEP;
        step(1'b0);
        supply_mv = 1700;
        step(1'b0);
        rd(6'h11);
        check({4'h0, rv}, 12'h00F);
        check({11'h000, mon_en}, 12'h000);
        i_power_state = supply_regs_pkg::PWR_ACTIVE;
        step(1'b1);
        check(12'(irq_seen), 12'(irq_exp));
        $display("test monitor done");
        supply_mv = 2600;
        step(1'b1);
        for (int i = 0; i < 32; i++) begin
            rng = xs(rng);
            set_thr({rng[7:5], 5'(i)});
        end
        set_thr(8'h00);
        $display("test threshold done");
        tally_and_finish;
    end
endmodule : test_supply_regs
